// File: hdl/ppc_pkg.sv
// Shared constants for the printout unit panel control block.
// Assumes a 50 MHz system clock and an APB register port.
package ppc_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 50_000_000;

  // Buffer copy time after power-up, in minutes
  localparam real COPY_TIME_MIN = 1.5;
  localparam longint unsigned COPY_CYC = longint'(COPY_TIME_MIN * 60.0 * CLK_HZ);

  // Button debounce hold time
  localparam int unsigned DEBOUNCE_TIME_MS = 10;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_TIME_MS * (CLK_HZ / 1000);

  // Half period of the red failure flash
  localparam int unsigned BLINK_TIME_MS = 250;
  localparam int unsigned BLINK_CYC     = BLINK_TIME_MS * (CLK_HZ / 1000);

  // Longest wait for one controller memory answer
  localparam int unsigned ACK_TIMEOUT_US = 100;
  localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * (CLK_HZ / 1_000_000);

  // Buffer geometry
  localparam int unsigned BUF_DEPTH = 1024;
  localparam int unsigned WORD_W    = 16;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_FORMAT_BIT = 0;
  localparam int unsigned CTRL_SOURCE_BIT = 1;
  localparam int unsigned CTRL_PRINT_BIT  = 2;
  localparam int unsigned CTRL_STOP_BIT   = 3;

  // Status register fields
  localparam int unsigned STAT_COPY_OK_BIT   = 0;
  localparam int unsigned STAT_COPY_FAIL_BIT = 1;
  localparam int unsigned STAT_PRINTING_BIT  = 2;
  localparam int unsigned STAT_TABLE_BIT     = 3;
  localparam int unsigned STAT_COL80_BIT     = 4;
  localparam int unsigned STAT_SUPPLY_BIT    = 5;
  localparam int unsigned STAT_EXT_BIT       = 6;

  // Reset values of the selections
  localparam logic FORMAT_RESET = 1'b0;   // Ladder diagram
  localparam logic SOURCE_RESET = 1'b1;   // Larger controller models

  // Printer control codes
  localparam logic [7:0] CODE_COMPRESSED = 8'h0f;
  localparam logic [7:0] CODE_NORMAL     = 8'h12;
  localparam logic [7:0] CODE_FORMAT_SELECT_BUTTON_FEED  = 8'h0c;

  // Copy sequencer states
  typedef enum logic [2:0] {
    CP_PACE,
    CP_FETCH,
    CP_OK,
    CP_FAIL_FLASH,
    CP_FAIL_DARK
  } ppc_copy_t;

  // Print sequencer states
  typedef enum logic [2:0] {
    PR_IDLE,
    PR_COLUMNS,
    PR_HEADER,
    PR_BODY,
    PR_FEED,
    PR_TABLE
  } ppc_print_t;

endpackage : ppc_pkg

// File: hdl/ppc_press_detect.sv
// Debounced press detector for one front-panel button.
// Assumes the button level is synchronous to the clock, high when pressed.
`timescale 1ns/100ps
module ppc_press_detect #(
  parameter int unsigned HOLD_CYCLES = 500_000
) (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Asynchronous reset, active low
  input  wire logic level,    // Raw button level
  output logic      press     // One-cycle pulse per press
);

  logic [31:0] hold_q;
  logic        stable_q;

  // Accept a new level only after it has held steady
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q   <= 32'h0;
      stable_q <= 1'b0;
    end else if (level == stable_q) begin
      hold_q <= 32'h0;
    end else if (hold_q >= HOLD_CYCLES - 1) begin
      hold_q   <= 32'h0;
      stable_q <= level;
    end else begin
      hold_q <= hold_q + 32'h1;
    end
  end

  // Pulse on the debounced rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      press <= 1'b0;
    end else begin
      press <= (level != stable_q) && (hold_q >= HOLD_CYCLES - 1) && level;
    end
  end

endmodule : ppc_press_detect

// File: hdl/ppc_panel.sv
// Panel control of the printout unit: buffer copy, lamps, selections, print stream.
// Assumes synchronous panel inputs, a handshaked controller memory port and a
// byte-wide printer stream with valid and ready; APB slave for software.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module ppc_panel
  import ppc_pkg::*;
#(
  parameter longint unsigned COPY_CYCLES     = ppc_pkg::COPY_CYC,
  parameter int unsigned     DEBOUNCE_CYCLES = ppc_pkg::DEBOUNCE_CYC,
  parameter int unsigned     BLINK_CYCLES    = ppc_pkg::BLINK_CYC,
  parameter int unsigned     ACK_CYCLES      = ppc_pkg::ACK_TIMEOUT_CYC,
  parameter int unsigned     DEPTH           = ppc_pkg::BUF_DEPTH,
  parameter int unsigned     AW              = $clog2(ppc_pkg::BUF_DEPTH)
) (
  input  wire logic              CLK_SYS,                // System clock
  input  wire logic              RSTN,                   // Asynchronous reset, active low
  input  wire logic              PSEL,                   // APB select
  input  wire logic              PENABLE,                // APB access phase
  input  wire logic              PWRITE,                 // APB write
  input  wire logic [7:0]        PADDR,                  // APB byte address
  input  wire logic [31:0]       PWDATA,                 // APB write data
  output logic      [31:0]       PRDATA,                 // APB read data
  output logic                   PREADY,                 // APB ready
  output logic                   PSLVERR,                // APB error, unmapped address
  input  wire logic              FORMAT_SELECT_BUTTON,   // Format toggle button
  input  wire logic              SOURCE_MODEL_BUTTON,    // Source model toggle button
  input  wire logic              PRINT_START_BUTTON,     // Print start button
  input  wire logic              STOP_BUTTON,            // Stop button
  input  wire logic              COLUMN_SWITCH_80,       // High selects 80-column compressed
  input  wire logic              SUPPLY_GOOD,            // 5 V present and in tolerance
  input  wire logic              SUPPLY_SOURCE_SWITCH,   // High for external supply
  output logic                   FORMAT_LAMP_GREEN,      // Format lamp green element
  output logic                   FORMAT_LAMP_RED,        // Format lamp red element
  output logic                   SOURCE_LAMP_GREEN,      // Source lamp green element
  output logic                   SOURCE_LAMP_RED,        // Source lamp red element
  output logic                   SUPPLY_OK_LAMP,         // Supply lamp
  output logic                   MEM_REQ,                // Controller memory read request
  output logic      [AW-1:0]     MEM_ADDR,               // Controller memory word address
  input  wire logic [WORD_W-1:0] MEM_RDATA,              // Controller memory read data
  input  wire logic              MEM_ACK,                // Read answer valid
  input  wire logic              MEM_ERR,                // Read answer faulty
  output logic                   PRN_VALID,              // Printer byte valid
  output logic      [7:0]        PRN_DATA,               // Printer byte
  input  wire logic              PRN_READY               // Printer accepts byte
);

  localparam int unsigned WORD_PERIOD = int'(COPY_CYCLES / DEPTH);

  ppc_copy_t         copy_q;
  ppc_print_t        print_q;
  logic [WORD_W-1:0] buf_mem [DEPTH];
  logic [AW:0]       copy_cnt_q;
  logic [31:0]       pace_q;
  logic [31:0]       wait_q;
  logic [31:0]       blink_cnt_q;
  logic              blink_q;
  logic              format_q;     // 0 ladder, 1 Boolean
  logic              source_q;     // 0 small model, 1 larger models
  logic              stop_q;
  logic              half_q;       // Which byte of the word is next
  logic [AW:0]       rd_idx_q;
  logic [WORD_W-1:0] rd_word;
  logic              press_format;
  logic              press_source;
  logic              press_print;
  logic              press_stop;
  logic              apb_access;
  logic              apb_wr_ctrl;
  logic              sw_print;
  logic              sw_stop;
  logic              byte_free;
  logic              copy_ok;

  // Debounced press pulses of the four panel buttons
  ppc_press_detect #(.HOLD_CYCLES(DEBOUNCE_CYCLES)) u_press_format (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .level (FORMAT_SELECT_BUTTON),
    .press (press_format)
  );
  ppc_press_detect #(.HOLD_CYCLES(DEBOUNCE_CYCLES)) u_press_source (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .level (SOURCE_MODEL_BUTTON),
    .press (press_source)
  );
  ppc_press_detect #(.HOLD_CYCLES(DEBOUNCE_CYCLES)) u_press_print (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .level (PRINT_START_BUTTON),
    .press (press_print)
  );
  ppc_press_detect #(.HOLD_CYCLES(DEBOUNCE_CYCLES)) u_press_stop (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .level (STOP_BUTTON),
    .press (press_stop)
  );

  // APB decode; writes take effect on the edge that samples PREADY high
  assign apb_access  = PSEL && PENABLE && PREADY;
  assign apb_wr_ctrl = apb_access && PWRITE && (PADDR == REG_CTRL);
  assign sw_print    = apb_wr_ctrl && PWDATA[CTRL_PRINT_BIT];
  assign sw_stop     = apb_wr_ctrl && PWDATA[CTRL_STOP_BIT];
  assign copy_ok     = (copy_q == CP_OK);
  assign byte_free   = !PRN_VALID || PRN_READY;
  assign rd_word     = buf_mem[rd_idx_q[AW-1:0]];

  // One wait state: PREADY rises in the second access cycle
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
      if (PSEL && PENABLE && !PREADY) begin
        case (PADDR)
          REG_CTRL: begin
            PRDATA[CTRL_FORMAT_BIT] <= format_q;
            PRDATA[CTRL_SOURCE_BIT] <= source_q;
          end
          REG_STATUS: begin
            PRDATA[STAT_COPY_OK_BIT]   <= copy_ok;
            PRDATA[STAT_COPY_FAIL_BIT] <= (copy_q == CP_FAIL_FLASH) || (copy_q == CP_FAIL_DARK);
            PRDATA[STAT_PRINTING_BIT]  <= (print_q != PR_IDLE);
            PRDATA[STAT_TABLE_BIT]     <= (print_q == PR_TABLE);
            PRDATA[STAT_COL80_BIT]     <= COLUMN_SWITCH_80;
            PRDATA[STAT_SUPPLY_BIT]    <= SUPPLY_GOOD;
            PRDATA[STAT_EXT_BIT]       <= SUPPLY_SOURCE_SWITCH;
          end
          REG_COUNT: begin
            PRDATA[AW:0] <= copy_cnt_q;
          end
          default: begin
            PSLVERR <= 1'b1;
          end
        endcase
      end
    end
  end

  // Listing format: button toggles once the copy is ok, software may set directly
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      format_q <= FORMAT_RESET;
    end else if (apb_wr_ctrl) begin
      format_q <= PWDATA[CTRL_FORMAT_BIT];
    end else if (press_format && copy_ok) begin
      format_q <= !format_q;
    end
  end

  // Source model: button toggles once the copy is ok, software may set directly
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      source_q <= SOURCE_RESET;
    end else if (apb_wr_ctrl) begin
      source_q <= PWDATA[CTRL_SOURCE_BIT];
    end else if (press_source && copy_ok) begin
      source_q <= !source_q;
    end
  end

  // Copy sequencer: paced fetches spread the copy over the full copy time
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      copy_q     <= CP_PACE;
      copy_cnt_q <= '0;
      pace_q     <= 32'h0;
      wait_q     <= 32'h0;
      MEM_REQ    <= 1'b0;
      MEM_ADDR   <= '0;
    end else begin
      case (copy_q)
        CP_PACE: begin
          if (pace_q >= WORD_PERIOD - 1) begin
            pace_q   <= 32'h0;
            wait_q   <= 32'h0;
            MEM_REQ  <= 1'b1;
            MEM_ADDR <= copy_cnt_q[AW-1:0];
            copy_q   <= CP_FETCH;
          end else begin
            pace_q <= pace_q + 32'h1;
          end
        end
        CP_FETCH: begin
          if (MEM_ACK && MEM_ERR) begin
            MEM_REQ <= 1'b0;
            copy_q  <= CP_FAIL_FLASH;
          end else if (MEM_ACK) begin
            MEM_REQ    <= 1'b0;
            copy_cnt_q <= copy_cnt_q + 1'b1;
            copy_q     <= (copy_cnt_q == (AW+1)'(DEPTH - 1)) ? CP_OK : CP_PACE;
          end else if (wait_q >= ACK_CYCLES - 1) begin
            MEM_REQ <= 1'b0;
            copy_q  <= CP_FAIL_DARK;
          end else begin
            wait_q <= wait_q + 32'h1;
          end
        end
        CP_OK: begin
          copy_q <= CP_OK;
        end
        CP_FAIL_FLASH: begin
          copy_q <= CP_FAIL_FLASH;
        end
        CP_FAIL_DARK: begin
          copy_q <= CP_FAIL_DARK;
        end
        default: begin
          copy_q <= CP_PACE;
        end
      endcase
    end
  end

  // Local buffer write on each good memory answer
  always_ff @(posedge CLK_SYS) begin
    if (copy_q == CP_FETCH && MEM_ACK && !MEM_ERR) begin
      buf_mem[copy_cnt_q[AW-1:0]] <= MEM_RDATA;
    end
  end

  // Flash divider for the failure indication
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q >= BLINK_CYCLES - 1) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // Lamp drivers; format and source lamps dark until the copy has ended
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      FORMAT_LAMP_GREEN <= 1'b0;
      FORMAT_LAMP_RED   <= 1'b0;
      SOURCE_LAMP_GREEN <= 1'b0;
      SOURCE_LAMP_RED   <= 1'b0;
      SUPPLY_OK_LAMP    <= 1'b0;
    end else begin
      FORMAT_LAMP_GREEN <= copy_ok && !format_q;
      FORMAT_LAMP_RED   <= (copy_ok && format_q) || (copy_q == CP_FAIL_FLASH && blink_q);
      SOURCE_LAMP_GREEN <= copy_ok && source_q;
      SOURCE_LAMP_RED   <= (copy_ok && !source_q) || (copy_q == CP_FAIL_FLASH && blink_q);
      SUPPLY_OK_LAMP    <= SUPPLY_GOOD;
    end
  end

  // Stop request; taken only in the column, header and body states, cleared in idle and feed
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      stop_q <= 1'b0;
    end else if ((press_stop || sw_stop) && (print_q == PR_BODY || print_q == PR_COLUMNS
                                             || print_q == PR_HEADER)) begin
      stop_q <= 1'b1;
    end else if (print_q == PR_IDLE || print_q == PR_FEED) begin
      stop_q <= 1'b0;
    end
  end

  // Print sequencer: column code, header, body bytes, format_select_button feed, outputs table
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      print_q   <= PR_IDLE;
      PRN_VALID <= 1'b0;
      PRN_DATA  <= 8'h00;
      half_q    <= 1'b0;
      rd_idx_q  <= '0;
    end else begin
      if (PRN_READY) begin
        PRN_VALID <= 1'b0;
      end
      case (print_q)
        PR_IDLE: begin
          if ((press_print || sw_print) && copy_ok) begin
            rd_idx_q <= '0;
            half_q   <= 1'b0;
            print_q  <= PR_COLUMNS;
          end
        end
        PR_COLUMNS: begin
          if (byte_free) begin
            PRN_VALID <= 1'b1;
            PRN_DATA  <= COLUMN_SWITCH_80 ? CODE_COMPRESSED : CODE_NORMAL;
            print_q   <= PR_HEADER;
          end
        end
        PR_HEADER: begin
          if (byte_free) begin
            PRN_VALID <= 1'b1;
            PRN_DATA  <= {6'h00, source_q, format_q};
            print_q   <= PR_BODY;
          end
        end
        PR_BODY: begin
          if (byte_free) begin
            if (stop_q && !format_q) begin
              print_q <= PR_IDLE;
            end else if (stop_q || rd_idx_q == (AW+1)'(DEPTH)) begin
              print_q <= PR_FEED;
            end else begin
              PRN_VALID <= 1'b1;
              PRN_DATA  <= half_q ? rd_word[7:0] : rd_word[WORD_W-1:8];
              half_q    <= !half_q;
              if (half_q) begin
                rd_idx_q <= rd_idx_q + 1'b1;
              end
            end
          end
        end
        PR_FEED: begin
          if (byte_free) begin
            PRN_VALID <= 1'b1;
            PRN_DATA  <= CODE_FORMAT_SELECT_BUTTON_FEED;
            rd_idx_q  <= '0;
            print_q   <= PR_TABLE;
          end
        end
        PR_TABLE: begin
          // Outputs table runs to its end; stop has no effect here
          if (byte_free) begin
            if (rd_idx_q == (AW+1)'(DEPTH)) begin
              print_q <= PR_IDLE;
            end else begin
              PRN_VALID <= 1'b1;
              PRN_DATA  <= rd_word[7:0];
              rd_idx_q  <= rd_idx_q + 1'b1;
            end
          end
        end
        default: begin
          print_q <= PR_IDLE;
        end
      endcase
    end
  end

endmodule : ppc_panel

// File: tb/ppc_panel_properties.sv
// Port checker for the panel block.
// Bound into ppc_panel; needs its address width.
`timescale 1ns/100ps
module ppc_panel_properties #(
  parameter int unsigned AW = 4
) (
  input wire logic          CLK_SYS,           // Clock
  input wire logic          RSTN,              // Reset, active low
  input wire logic          PSEL,              // APB select
  input wire logic          PENABLE,           // APB access
  input wire logic          PWRITE,            // APB write
  input wire logic [7:0]    PADDR,             // APB address
  input wire logic [31:0]   PWDATA,            // APB write data
  input wire logic [31:0]   PRDATA,            // APB read data
  input wire logic          PREADY,            // APB ready
  input wire logic          PSLVERR,           // APB error
  input wire logic          SUPPLY_GOOD,       // Supply ok
  input wire logic          SUPPLY_OK_LAMP,    // Supply lamp
  input wire logic          FORMAT_LAMP_GREEN, // Format green
  input wire logic          FORMAT_LAMP_RED,   // Format red
  input wire logic          SOURCE_LAMP_GREEN, // Source green
  input wire logic          SOURCE_LAMP_RED,   // Source red
  input wire logic          MEM_REQ,           // Memory request
  input wire logic [AW-1:0] MEM_ADDR,          // Memory address
  input wire logic          MEM_ACK,           // Memory answer
  input wire logic          PRN_VALID,         // Printer valid
  input wire logic [7:0]    PRN_DATA,          // Printer byte
  input wire logic          PRN_READY          // Printer ready
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  logic ok_q;  // Copy ok seen

  // Both lamps went green
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ok_q <= 1'b0;
    end else if (FORMAT_LAMP_GREEN && SOURCE_LAMP_GREEN) begin
      ok_q <= 1'b1;
    end
  end

  // Bus steps
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_ctrl_wr;
    PSEL && PENABLE && PREADY && PWRITE && (PADDR == 8'h00) && ok_q;
  endsequence

  a_apb_wait: assert property (s_setup |=> !PREADY ##1 PREADY)
    else $error("no wait state");
  a_apb_unmapped: assert property (PREADY && (PADDR[1:0] == 2'b00) |-> (PSLVERR == (PADDR > 8'h08)))
    else $error("bad error flag");
  a_fmt_excl: assert property (!(FORMAT_LAMP_GREEN && FORMAT_LAMP_RED))
    else $error("format both colours");
  a_src_excl: assert property (!(SOURCE_LAMP_GREEN && SOURCE_LAMP_RED))
    else $error("source both colours");
  a_lamp_lit: assert property (ok_q |-> (FORMAT_LAMP_GREEN || FORMAT_LAMP_RED))
    else $error("format lamp dark");
  a_supply_off: assert property (!SUPPLY_GOOD |=> !SUPPLY_OK_LAMP)
    else $error("supply lamp lit");
  a_print_gated: assert property (PRN_VALID |-> ok_q)
    else $error("print before copy");
  a_prn_hold: assert property (PRN_VALID && !PRN_READY |=> PRN_VALID && $stable(PRN_DATA))
    else $error("byte not held");
  a_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("request not held");
  a_ctrl_fmt: assert property (s_ctrl_wr ##0 PWDATA[0] |-> ##[1:3] FORMAT_LAMP_RED)
    else $error("format write lost");
  a_ctrl_src: assert property (s_ctrl_wr ##0 !PWDATA[1] |-> ##[1:3] SOURCE_LAMP_RED)
    else $error("source write lost");
endmodule : ppc_panel_properties

bind ppc_panel ppc_panel_properties #(.AW(AW)) i_ppc_panel_properties (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SUPPLY_GOOD(SUPPLY_GOOD), .SUPPLY_OK_LAMP(SUPPLY_OK_LAMP),
  .FORMAT_LAMP_GREEN(FORMAT_LAMP_GREEN), .FORMAT_LAMP_RED(FORMAT_LAMP_RED),
  .SOURCE_LAMP_GREEN(SOURCE_LAMP_GREEN), .SOURCE_LAMP_RED(SOURCE_LAMP_RED),
  .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
  .PRN_VALID(PRN_VALID), .PRN_DATA(PRN_DATA), .PRN_READY(PRN_READY));

// File: tb/ppc_far_model.sv
// Far side model: controller user memory and parallel printer.
// Assumes a four-bit word address, one shared clock.
`timescale 1ns/100ps
module ppc_far_model (
  input  wire logic        clk,       // System clock
  input  wire logic        rst_n,     // Reset, active low
  input  wire logic        mem_req,   // Word request
  input  wire logic [3:0]  mem_addr,  // Word address
  input  wire logic        err_mode,  // Answer with fault
  output logic      [15:0] mem_rdata, // Word answer
  output logic             mem_ack,   // Answer strobe
  output logic             mem_err,   // Answer fault
  output logic             prn_ready  // Printer accepts
);
  logic [31:0] rs_q;   // Stall pattern
  logic [1:0]  wait_q; // Answer delay
  logic        busy_q; // Request in hand

  // Printer stalls a quarter of cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q      <= 32'h1d2b;
      prn_ready <= 1'b0;
    end else begin
      rs_q      <= {rs_q[30:0], rs_q[31] ^ rs_q[21] ^ rs_q[1] ^ rs_q[0]};
      prn_ready <= rs_q[0] | rs_q[1];
    end
  end

  // Memory answers after 1 to 4 cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q    <= 1'b0;
      wait_q    <= 2'd0;
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= 16'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      mem_rdata <= ~mem_rdata;  // Idle data keeps changing
      if (busy_q) begin
        if (wait_q == 2'd0) begin
          busy_q    <= 1'b0;
          mem_ack   <= 1'b1;
          mem_err   <= err_mode;
          mem_rdata <= {4'h3, mem_addr, 4'hc, ~mem_addr};
        end else begin
          wait_q <= wait_q - 2'd1;
        end
      end else if (mem_req && !mem_ack) begin
        busy_q <= 1'b1;
        wait_q <= rs_q[3:2];
      end
    end
  end
endmodule : ppc_far_model

// File: tb/test_printout_unit_panel_control.sv
// Self-checking bench for the panel block.
// Assumes 16 words, 128 cycles a word, debounce 4.
`timescale 1ns/100ps
module test_printout_unit_panel_control;
  import ppc_pkg::*;
  localparam int unsigned DB = 4;  // Debounce length
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, prn_data;
  logic [31:0] pwdata, prdata, rs, rd;
  logic [3:0]  btn, mem_addr;  // Buttons: format, source, print, stop
  logic        col80, sup_good, sup_ext, err_mode, er, fmt;
  logic        fg, fr, sg, sr, sup_lamp, mem_req, mem_ack, mem_err, prn_valid, prn_ready;
  logic [15:0] mem_rdata;
  logic [7:0]  got[$], exp_q[$];
  int          mismatches, cmp_count, n;

  ppc_panel #(.COPY_CYCLES(2048), .DEBOUNCE_CYCLES(DB), .BLINK_CYCLES(8), .ACK_CYCLES(16),
    .DEPTH(16), .AW(4)) i_ppc_panel (
    .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FORMAT_SELECT_BUTTON(btn[0]), .SOURCE_MODEL_BUTTON(btn[1]), .PRINT_START_BUTTON(btn[2]),
    .STOP_BUTTON(btn[3]), .COLUMN_SWITCH_80(col80), .SUPPLY_GOOD(sup_good),
    .SUPPLY_SOURCE_SWITCH(sup_ext), .FORMAT_LAMP_GREEN(fg), .FORMAT_LAMP_RED(fr),
    .SOURCE_LAMP_GREEN(sg), .SOURCE_LAMP_RED(sr), .SUPPLY_OK_LAMP(sup_lamp),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack),
    .MEM_ERR(mem_err), .PRN_VALID(prn_valid), .PRN_DATA(prn_data), .PRN_READY(prn_ready));

  ppc_far_model i_ppc_far_model (.clk(clk_sys), .rst_n(rstn), .mem_req(mem_req),
    .mem_addr(mem_addr), .err_mode(err_mode), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_err(mem_err), .prn_ready(prn_ready));

  // Clock and printer byte capture
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (prn_valid === 1'b1 && prn_ready === 1'b1) begin
      got.push_back(prn_data);
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Full expected stream for one print
  function automatic void build(input logic f);
    exp_q.delete();
    exp_q.push_back(col80 ? CODE_COMPRESSED : CODE_NORMAL);
    exp_q.push_back({6'h0, 1'b1, f});
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back({4'h3, 4'(i)});
      exp_q.push_back({4'hc, ~4'(i)});
    end
    exp_q.push_back(CODE_FORMAT_SELECT_BUTTON_FEED);
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back({4'hc, ~4'(i)});
    end
  endfunction : build

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Mismatches %0d, compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic press(input int b);
    @(posedge clk_sys);
    btn[b] <= 1'b1;
    repeat (DB + 3) @(posedge clk_sys);
    btn[b] <= 1'b0;
    repeat (DB + 6) @(posedge clk_sys);
  endtask : press

  // One print, stopped early when stop_at is nonzero
  task automatic print_run(input int stop_at);
    int q, k, m;
    rs = xs(rs);
    col80 <= rs[0];
    got.delete();
    @(posedge clk_sys);
    build(fmt);
    press(2);
    if (stop_at > 0) begin
      press(3);
    end
    q = 0;
    k = 0;
    while (q < 40 && k < 5000) begin
      @(posedge clk_sys);
      k++;
      q = (prn_valid === 1'b1) ? 0 : q + 1;
    end
    m = got.size();
    if (stop_at == 0) check(32'(m), 32'd51);
    else if (fmt) check(32'(m < 51 && m > 17 && got[m-17] === CODE_FORMAT_SELECT_BUTTON_FEED), 32'h1);
    else check(32'(m < 35), 32'h1);
    k = (stop_at > 0 && fmt) ? m - 17 : m;
    for (int i = 0; i < k && i < 51; i++) check(got[i], exp_q[i]);
    for (int i = 0; stop_at > 0 && fmt && i < 17 && m > 17; i++) check(got[m-17+i], exp_q[34+i]);
  endtask : print_run

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end

  initial begin
    clk_sys = 1'b0; rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; btn = 4'h0; col80 = 1'b0; sup_good = 1'b1;
    sup_ext = 1'b0; err_mode = 1'b0; mismatches = 0; cmp_count = 0; rs = 32'h9240;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check({fg, fr, sg, sr}, 4'h0);
    press(2);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[2:0], 3'b000);
    apb(1'b0, 8'h10, 32'h0);
    check(er, 1'b1);
    while (fg !== 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    check({fg, fr, sg, sr}, 4'b1010);
    apb(1'b0, REG_COUNT, 32'h0);
    check(rd, 32'd16);
    rs = xs(rs);
    col80 <= rs[0];
    sup_ext <= rs[1];
    sup_good <= rs[2];
    repeat (3) @(posedge clk_sys);
    check(sup_lamp, sup_good);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd[6:0], {sup_ext, sup_good, col80, 4'b0001});
    sup_good <= 1'b1;
    n = rs[4:3] + 1;
    for (int i = 0; i < n; i++) press(0);
    fmt = n[0];
    check({fg, fr}, fmt ? 2'b01 : 2'b10);
    press(1);
    check({sg, sr}, 2'b01);
    press(1);
    check({sg, sr}, 2'b10);
    for (int f = 0; f < 2; f++) begin
      fmt = f[0];
      apb(1'b1, REG_CTRL, {30'h0, 1'b1, fmt});
      apb(1'b0, REG_CTRL, 32'h0);
      check(rd[1:0], {1'b1, fmt});
      print_run(0);
      print_run(1);
    end
    err_mode <= 1'b1;
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    while (fr !== 1'b1) @(posedge clk_sys);
    check({fg, fr, sg, sr}, 4'b0101);
    got.delete();
    press(2);
    repeat (20) @(posedge clk_sys);
    check(32'(got.size()), 32'h0);
    conclude();
  end
endmodule : test_printout_unit_panel_control
